// File: logic/sef_consts.vh
// Register map, field positions and reset values of the SPI flag block.
`ifndef SEF_CONSTS_VH
`define SEF_CONSTS_VH

// Byte addresses of the word registers on the Avalon-MM slave.
`define SEF_ADDR_W        5
`define SEF_OFF_CTRL      5'h00
`define SEF_OFF_DATA      5'h04
`define SEF_OFF_DIV       5'h08
`define SEF_OFF_STAT      5'h0C
`define SEF_OFF_CLR       5'h10
`define SEF_OFF_IEN       5'h14

// Control register fields.
`define SEF_CTL_DONE_BIT  7
`define SEF_CTL_WRITE_COLLISION_FLAG_BIT  6
`define SEF_CTL_MODE_FAULT_FLAG_BIT  5
`define SEF_CTL_OVR_BIT   4
`define SEF_CTL_SSM_HI    3
`define SEF_CTL_SSM_LO    2
`define SEF_CTL_MEN_BIT   1
`define SEF_CTL_PEN_BIT   0

// Status, clear and enable layout (one bit per event flag).
`define SEF_FLG_DONE      3
`define SEF_FLG_WRITE_COLLISION_FLAG      2
`define SEF_FLG_MODE_FAULT_FLAG      1
`define SEF_FLG_OVR       0

// Slave-select modes.
`define SEF_SSM_3WIRE     2'h0
`define SEF_SSM_4WIRE     2'h1

// Reset values, and the index of the last bit of a byte.
`define SEF_RST_SSM       2'h1
`define SEF_RST_DIV       8'h04
`define SEF_LAST_BIT      3'h7

`endif

// File: logic/sef_sync2.v
// Two flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/100ps

module sef_sync2 #(
  parameter WIDTH = 1                         // Number of bits carried.
) (
  input  wire             clk_in,             // System clock.
  input  wire             rst_n_in,           // Reset, active low.
  input  wire [WIDTH-1:0] async_in,           // Pins from outside the domain.
  output wire [WIDTH-1:0] sync_out            // Second stage, safe to use.
);

  reg [WIDTH-1:0] meta_ff;                    // First stage, read by stage two only.
  reg [WIDTH-1:0] sync_ff;                    // Second stage.

  // Both stages clear to zero under reset; pins are ignored until release.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_ff <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// File: logic/sef_core.v
// SPI port with sticky event flags, interrupt and Avalon-MM registers.
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "sef_consts.vh"

module sef_core (
  input  wire                   clk_in,             // System clock, 20 MHz.
  input  wire                   arst_n_in,          // Async reset, active low.
  input  wire [`SEF_ADDR_W-1:0] avs_address_in,     // Byte address.
  input  wire                   avs_read_in,        // Read request.
  input  wire                   avs_write_in,       // Write request.
  input  wire [31:0]            avs_writedata_in,   // Write data.
  output wire [31:0]            avs_readdata_out,   // Read data.
  output wire                   avs_waitrequest_out,// High until answered.
  output wire                   irq_out,            // Level interrupt.
  input  wire                   sck_in,             // Serial clock pin in.
  output wire                   sck_out,            // Serial clock pin out.
  output wire                   sck_oe_out,         // Drive serial clock.
  input  wire                   mosi_in,            // Master-out pin in.
  output wire                   mosi_out,           // Master-out pin out.
  output wire                   mosi_oe_out,        // Drive master-out.
  input  wire                   miso_in,            // Master-in pin in.
  output wire                   miso_out,           // Master-in pin out.
  output wire                   miso_oe_out,        // Drive master-in.
  input  wire                   slave_select_n_in,  // Select pin in.
  output wire                   slave_select_n_out, // Select pin out.
  output wire                   slave_select_n_oe_out // Drive select pin.
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers.

  reg  [1:0] rst_sync_ff;                     // Reset release chain.
  wire       rst_n;                           // Synchronised reset.
  wire [3:0] pins_s;                          // Synchronised pins.
  wire       sck_s;                           // Serial clock level.
  wire       mosi_s;                          // Master-out level.
  wire       miso_s;                          // Master-in level.
  wire       ss_s;                            // Select level.

  // Reset asserts at once but is released two edges late.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // All link pins share one two-stage synchroniser so their skew is equal.
  sef_sync2 #(
    .WIDTH    (4)
  ) u_pin_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n),
    .async_in ({slave_select_n_in, miso_in, mosi_in, sck_in}),
    .sync_out (pins_s)
  );
  assign sck_s  = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign ss_s   = pins_s[3];

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg [1:0]  ss_mode_ff, nxt_ss_mode;         // Slave-select mode.
  reg        master_en_ff, nxt_master_en;     // Master enable.
  reg        port_en_ff, nxt_port_en;         // Port enable.
  reg [7:0]  div_ff, nxt_div;                 // Half period of master clock, less one.
  reg [3:0]  ien_ff, nxt_ien;                 // Interrupt enables.
  reg [3:0]  flags_ff, nxt_flags;             // Sticky event flags.
  reg [7:0]  tx_buf_ff, nxt_tx_buf;           // Transmit buffer.
  reg        tx_full_ff, nxt_tx_full;         // Transmit buffer holds data.
  reg [7:0]  shift_ff, nxt_shift;             // Shift register.
  reg        shift_full_ff, nxt_shift_full;   // Shift register loaded.
  reg        smp_ff, nxt_smp;                 // Bit sampled on rising edge.
  reg [2:0]  bit_cnt_ff, nxt_bit_cnt;         // Bits shifted this byte.
  reg [7:0]  rx_buf_ff, nxt_rx_buf;           // Receive buffer.
  reg        rx_full_ff, nxt_rx_full;         // Unread byte present.
  reg        busy_ff, nxt_busy;               // Master transfer running.
  reg        sck_ff, nxt_sck;                 // Master clock level.
  reg [7:0]  div_cnt_ff, nxt_div_cnt;         // Divider countdown.
  reg        sck_prev_ff;                     // Last serial clock level.
  reg        ss_prev_ff;                      // Last select level.
  reg        wait_ff;                         // Waitrequest register.
  reg [31:0] rdata_ff, nxt_rdata;             // Read data register.
  reg        irq_ff;                          // Interrupt register.
  reg        mosi_ff, mosi_oe_ff;             // Master-out pin drive.
  reg        miso_ff, miso_oe_ff;             // Master-in pin drive.
  reg        sck_oe_ff;                       // Serial clock drive enable.
  reg        ss_out_ff, ss_oe_ff;             // Select pin drive.

  ////////////////////////////////////////////////////////////////////////////
  // Decode of bus, modes and edges.

  wire req       = avs_read_in | avs_write_in;          // Request present.
  wire wr_acc    = avs_write_in & ~wait_ff;             // Write takes effect.
  wire rd_acc    = avs_read_in & ~wait_ff;              // Read completes.
  wire wr_ctrl   = wr_acc & (avs_address_in == `SEF_OFF_CTRL);
  wire wr_data   = wr_acc & (avs_address_in == `SEF_OFF_DATA);
  wire wr_div    = wr_acc & (avs_address_in == `SEF_OFF_DIV);
  wire wr_clr    = wr_acc & (avs_address_in == `SEF_OFF_CLR);
  wire wr_ien    = wr_acc & (avs_address_in == `SEF_OFF_IEN);
  wire rd_data   = rd_acc & (avs_address_in == `SEF_OFF_DATA);
  wire three_w   = (ss_mode_ff == `SEF_SSM_3WIRE);
  wire four_w    = (ss_mode_ff == `SEF_SSM_4WIRE);
  wire slave_m   = port_en_ff & ~master_en_ff;
  wire master_m  = port_en_ff & master_en_ff;
  wire slave_sel = slave_m & (three_w | (four_w & ~ss_s));
  wire ss_fall   = ss_prev_ff & ~ss_s;
  wire fault     = master_m & four_w & ~ss_s;
  wire tick      = busy_ff & (div_cnt_ff == 8'h00);
  wire rise      = slave_sel ? (sck_s & ~sck_prev_ff) : (tick & ~sck_ff);
  wire fall      = slave_sel ? (~sck_s & sck_prev_ff) : (tick & sck_ff);
  wire in_xfer   = busy_ff | (slave_sel & (bit_cnt_ff != 3'h0));

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic of the port, buffers and flags.

  // Order matters: clears from software come first and hardware events
  // after, so an event in the same cycle as its clear is never lost.
  always @* begin
    nxt_ss_mode    = ss_mode_ff;
    nxt_master_en  = master_en_ff;
    nxt_port_en    = port_en_ff;
    nxt_div        = div_ff;
    nxt_ien        = ien_ff;
    nxt_flags      = flags_ff;
    nxt_tx_buf     = tx_buf_ff;
    nxt_tx_full    = tx_full_ff;
    nxt_shift      = shift_ff;
    nxt_shift_full = shift_full_ff;
    nxt_smp        = smp_ff;
    nxt_bit_cnt    = bit_cnt_ff;
    nxt_rx_buf     = rx_buf_ff;
    nxt_rx_full    = rx_full_ff;
    nxt_busy       = busy_ff;
    nxt_sck        = sck_ff;
    nxt_div_cnt    = div_cnt_ff;

    // Software writes to configuration registers.
    if (wr_ctrl) begin
      nxt_ss_mode   = avs_writedata_in[`SEF_CTL_SSM_HI:`SEF_CTL_SSM_LO];
      nxt_master_en = avs_writedata_in[`SEF_CTL_MEN_BIT];
      nxt_port_en   = avs_writedata_in[`SEF_CTL_PEN_BIT];
    end
    if (wr_div) begin
      nxt_div = avs_writedata_in[7:0];
    end
    if (wr_ien) begin
      nxt_ien = avs_writedata_in[3:0];
    end
    // Flags fall only by a write of ones to the clear register.
    if (wr_clr) begin
      nxt_flags = flags_ff & ~avs_writedata_in[3:0];
    end
    // Reading the data register frees the receive buffer.
    if (rd_data) begin
      nxt_rx_full = 1'b0;
    end

    // Master clock divider: one tick every div+1 system clocks.
    if (busy_ff) begin
      if (tick) begin
        nxt_div_cnt = div_ff;
        nxt_sck     = ~sck_ff;
      end else begin
        nxt_div_cnt = div_cnt_ff - 8'h01;
      end
    end

    // Leading edge samples, trailing edge shifts and counts the bit.
    if (rise) begin
      nxt_smp = slave_sel ? mosi_s : miso_s;
    end
    if (fall) begin
      nxt_shift   = {shift_ff[6:0], smp_ff};
      nxt_bit_cnt = bit_cnt_ff + 3'h1;
      if (bit_cnt_ff == `SEF_LAST_BIT) begin
        nxt_flags[`SEF_FLG_DONE] = 1'b1;
        nxt_busy = 1'b0;
        nxt_sck  = 1'b0;
        if (slave_m & rx_full_ff & ~rd_data) begin
          nxt_flags[`SEF_FLG_OVR] = 1'b1;
          // Old byte stays, the new one is simply not copied.
        end else begin
          nxt_rx_buf  = {shift_ff[6:0], smp_ff};
          nxt_rx_full = 1'b1;
        end
        // Buffered byte follows straight after the last edge.
        if (tx_full_ff) begin
          nxt_shift      = tx_buf_ff;
          nxt_tx_full    = 1'b0;
          nxt_shift_full = 1'b1;
        end else begin
          nxt_shift_full = 1'b0;
        end
      end
    end

    // Data write: collision if the buffer still waits, else load.
    if (wr_data) begin
      if (tx_full_ff) begin
        nxt_flags[`SEF_FLG_WRITE_COLLISION_FLAG] = 1'b1;
        // Buffer and shift register are left untouched.
      end else if (~nxt_shift_full & ~in_xfer) begin
        nxt_shift      = avs_writedata_in[7:0];
        nxt_shift_full = 1'b1;
      end else begin
        nxt_tx_buf  = avs_writedata_in[7:0];
        nxt_tx_full = 1'b1;
      end
    end

    // Master starts a byte whenever data sits in the shift register.
    if (master_m & ~busy_ff & shift_full_ff & ~fault) begin
      nxt_busy    = 1'b1;
      nxt_div_cnt = div_ff;
      nxt_sck     = 1'b0;
      nxt_bit_cnt = 3'h0;
    end

    // Select falling in four-wire slave mode restarts the byte; a
    // disabled port also clears it, the only restart in three-wire mode.
    if ((slave_m & four_w & ss_fall) | ~port_en_ff) begin
      nxt_bit_cnt = 3'h0;
      nxt_busy    = 1'b0;
      nxt_sck     = 1'b0;
    end

    // Another master pulled select low: give up the bus at once.
    if (fault) begin
      nxt_flags[`SEF_FLG_MODE_FAULT_FLAG] = 1'b1;
      nxt_master_en = 1'b0;
      nxt_port_en   = 1'b0;
      nxt_busy      = 1'b0;
      nxt_sck       = 1'b0;
      nxt_bit_cnt   = 3'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped and write-only addresses read as zero.

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_in)
      `SEF_OFF_CTRL: begin
        nxt_rdata[7:0] = {flags_ff, ss_mode_ff, master_en_ff, port_en_ff};
      end
      `SEF_OFF_DATA: begin
        nxt_rdata[7:0] = rx_buf_ff;
      end
      `SEF_OFF_DIV: begin
        nxt_rdata[7:0] = div_ff;
      end
      `SEF_OFF_STAT: begin
        nxt_rdata[3:0] = flags_ff;
      end
      `SEF_OFF_IEN: begin
        nxt_rdata[3:0] = ien_ff;
      end
      default: begin
        nxt_rdata = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  // Every output comes from a flop here; pin drives load from next-state values
  // and change with the state; only miso_oe_ff follows slave_sel one system clock late.
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ss_mode_ff    <= `SEF_RST_SSM;
      master_en_ff  <= 1'b0;
      port_en_ff    <= 1'b0;
      div_ff        <= `SEF_RST_DIV;
      ien_ff        <= 4'h0;
      flags_ff      <= 4'h0;
      tx_buf_ff     <= 8'h00;
      tx_full_ff    <= 1'b0;
      shift_ff      <= 8'h00;
      shift_full_ff <= 1'b0;
      smp_ff        <= 1'b0;
      bit_cnt_ff    <= 3'h0;
      rx_buf_ff     <= 8'h00;
      rx_full_ff    <= 1'b0;
      busy_ff       <= 1'b0;
      sck_ff        <= 1'b0;
      div_cnt_ff    <= 8'h00;
      sck_prev_ff   <= 1'b0;
      ss_prev_ff    <= 1'b0;  // Matches the synchroniser, no false fall.
      wait_ff       <= 1'b1;
      rdata_ff      <= 32'h0000_0000;
      irq_ff        <= 1'b0;
      mosi_ff       <= 1'b0;
      mosi_oe_ff    <= 1'b0;
      miso_ff       <= 1'b0;
      miso_oe_ff    <= 1'b0;
      sck_oe_ff     <= 1'b0;
      ss_out_ff     <= 1'b1;
      ss_oe_ff      <= 1'b0;
    end else begin
      ss_mode_ff    <= nxt_ss_mode;
      master_en_ff  <= nxt_master_en;
      port_en_ff    <= nxt_port_en;
      div_ff        <= nxt_div;
      ien_ff        <= nxt_ien;
      flags_ff      <= nxt_flags;
      tx_buf_ff     <= nxt_tx_buf;
      tx_full_ff    <= nxt_tx_full;
      shift_ff      <= nxt_shift;
      shift_full_ff <= nxt_shift_full;
      smp_ff        <= nxt_smp;
      bit_cnt_ff    <= nxt_bit_cnt;
      rx_buf_ff     <= nxt_rx_buf;
      rx_full_ff    <= nxt_rx_full;
      busy_ff       <= nxt_busy;
      sck_ff        <= nxt_sck;
      div_cnt_ff    <= nxt_div_cnt;
      sck_prev_ff   <= sck_s;
      ss_prev_ff    <= ss_s;
      // Answer one cycle after a request is seen, then drop again.
      wait_ff       <= ~(req & wait_ff);
      if (req & wait_ff) begin
        rdata_ff <= nxt_rdata;
      end
      irq_ff        <= |(nxt_flags & nxt_ien);
      mosi_ff       <= nxt_shift[7];
      mosi_oe_ff    <= nxt_master_en & nxt_port_en;
      miso_ff       <= nxt_shift[7];
      miso_oe_ff    <= slave_sel;
      sck_oe_ff     <= nxt_master_en & nxt_port_en;
      ss_out_ff     <= nxt_ss_mode[0];
      ss_oe_ff      <= nxt_master_en & nxt_port_en & nxt_ss_mode[1];
    end
  end

  assign avs_readdata_out      = rdata_ff;
  assign avs_waitrequest_out   = wait_ff;
  assign irq_out               = irq_ff;
  assign sck_out               = sck_ff;
  assign sck_oe_out            = sck_oe_ff;
  assign mosi_out              = mosi_ff;
  assign mosi_oe_out           = mosi_oe_ff;
  assign miso_out              = miso_ff;
  assign miso_oe_out           = miso_oe_ff;
  assign slave_select_n_out    = ss_out_ff;
  assign slave_select_n_oe_out = ss_oe_ff;

endmodule

// File: tb/sef_core_asserts.sv
// Checker for the bus handshake, interrupt and mode fault of the SPI block.
`timescale 1ns/100ps
`include "sef_consts.vh"
module sef_core_asserts (
  input wire                   clk_in,
  input wire                   arst_n_in,
  input wire [`SEF_ADDR_W-1:0] avs_address_in,
  input wire                   avs_read_in,
  input wire                   avs_write_in,
  input wire [31:0]            avs_writedata_in,
  input wire                   avs_waitrequest_out,
  input wire                   irq_out,
  input wire                   sck_in,
  input wire                   sck_oe_out,
  input wire                   slave_select_n_in,
  input wire                   slave_select_n_oe_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic [3:0] ien_ff;   // Shadow of the enable register.
  logic [7:0] ctl_ff;   // Shadow of the written control byte.
  logic [1:0] age_ff;   // Nonzero just after a clear or enable write.
  logic [3:0] fall_ff;  // Serial clock falls seen in this frame.
  logic       sck_d_ff; // Serial clock one cycle back.
  wire        acc = avs_write_in && !avs_waitrequest_out;
  wire        fall = sck_d_ff && !sck_in;
  wire        req = avs_read_in || avs_write_in;
  wire        wa = acc && (avs_address_in == `SEF_OFF_IEN);
  wire        wc = acc && (avs_address_in == `SEF_OFF_CLR);
  wire        flt = sck_oe_out && !slave_select_n_in && ctl_ff[3:2] == 2'h1;
  // Shadows follow accepted writes; hardware may still clear enables.
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ien_ff <= 4'h0;
      ctl_ff <= 8'h04;
      age_ff <= 2'h0;
      fall_ff <= 4'h0;
      sck_d_ff <= 1'b0;
    end else begin
      if (wa) ien_ff <= avs_writedata_in[3:0];
      if (acc && avs_address_in == `SEF_OFF_CTRL)
        ctl_ff <= avs_writedata_in[7:0];
      age_ff <= (wa || wc) ? 2'h3 : age_ff - {1'b0, age_ff != 2'h0};
      sck_d_ff <= sck_in;
      fall_ff <= slave_select_n_in ? 4'h0 : fall_ff + {3'h0, fall};
    end
  end
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence
  property p_bus_answer;
    $rose(req) |-> ##[1:2] s_ack;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
  property p_bus_idle;
    (!req) [*2] |-> avs_waitrequest_out;
  endproperty
  a_bus_idle: assert property (p_bus_idle) else $error("wait low at idle");
  property p_irq_gate;
    (ien_ff == 4'h0) [*3] |-> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq unenabled");
  property p_irq_fall;
    $fell(irq_out) |-> age_ff != 2'h0;
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq fell alone");
  property p_done_irq;
    fall_ff == 4'h7 && fall && ien_ff[`SEF_FLG_DONE] && ctl_ff[1:0] == 2'h1
      |-> ##[1:8] irq_out;
  endproperty
  a_done_irq: assert property (p_done_irq)
    else $error("no done irq");
  property p_mode_fault_flag_drop;
    flt |-> ##[1:6] !sck_oe_out;
  endproperty
  a_mode_fault_flag_drop: assert property (p_mode_fault_flag_drop)
    else $error("fault kept");
  property p_mode_fault_flag_irq;
    flt && ien_ff[`SEF_FLG_MODE_FAULT_FLAG] |-> ##[1:8] irq_out;
  endproperty
  a_mode_fault_flag_irq: assert property (p_mode_fault_flag_irq)
    else $error("no fault irq");
  property p_ss_quiet;
    (!ctl_ff[3]) [*3] |-> !slave_select_n_oe_out;
  endproperty
  a_ss_quiet: assert property (p_ss_quiet) else $error("select driven");
endmodule
bind sef_core sef_core_asserts sef_core_asserts_i (.clk_in, .arst_n_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_waitrequest_out, .irq_out, .sck_in, .sck_oe_out, .slave_select_n_in,
  .slave_select_n_oe_out);

// File: tb/sef_spi_partner.sv
// Behavioural SPI master on the far side of the port, clock mode 0.
`timescale 1ns/100ps
module sef_spi_partner (
  input  wire logic [7:0] byte_in,  // Byte to send, first bit highest.
  input  wire logic       go_in,    // Rising edge starts one frame.
  input  wire logic       miso_in,  // Line back from the slave.
  output logic            sck_out,  // Link clock, still between frames.
  output logic            mosi_out, // Data towards the slave.
  output logic            ss_n_out, // Select, active low.
  output logic [7:0]      rx_out    // Byte taken from the slave.
);
  localparam int HALF = 200; // Half of the 400 ns link period.
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
    rx_out = 8'h00;
  end
  // Data is set before each rise and sampled on it.
  always @(posedge go_in) begin
    #13;
    ss_n_out = 1'b0;
    #HALF;
    for (int i = 7; i >= 0; i--) begin
      mosi_out = byte_in[i];
      #HALF sck_out = 1'b1;
      rx_out = {rx_out[6:0], miso_in};
      #HALF sck_out = 1'b0;
    end
    mosi_out = ~mosi_out; // A released line must not hold its old level.
    #HALF ss_n_out = 1'b1;
  end
endmodule

// File: tb/spi_event_flag_logic_tb_top.sv
// Testbench for the SPI flag block: registers, flags, interrupt, faults.
`timescale 1ns/100ps
`include "sef_consts.vh"
`define SEF_CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, got, exp); end end
module spi_event_flag_logic_tb_top;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic [4:0]  avs_address_in = 5'h00;
  logic        avs_read_in = 1'b0;
  logic        avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] rd;
  logic        p_go = 1'b0;
  logic [7:0]  p_byte = 8'h00;
  wire  [31:0] avs_readdata_out;
  wire  [7:0]  p_rx;
  wire         stall, irq_out, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  wire         ss_o, ss_oe, p_sck, p_mosi, p_ss;
  int          error_cnt = 0;
  int          check_count = 0;
  // Pin levels from every party's drive; idle master-in echoes master-out.
  wire sck_w = sck_oe ? sck_o : p_sck;
  wire mosi_w = mosi_oe ? mosi_o : p_mosi;
  wire miso_w = miso_oe ? miso_o : mosi_w;
  wire ss_w = ss_oe ? ss_o : p_ss;
  sef_core sef_core_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(stall),
    .irq_out(irq_out), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_out(sck_oe),
    .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_out(mosi_oe),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe_out(miso_oe),
    .slave_select_n_in(ss_w), .slave_select_n_out(ss_o),
    .slave_select_n_oe_out(ss_oe));
  sef_spi_partner sef_spi_partner_i (.byte_in(p_byte), .go_in(p_go),
    .miso_in(miso_w), .sck_out(p_sck), .mosi_out(p_mosi), .ss_n_out(p_ss),
    .rx_out(p_rx));
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d);
    begin
      @(posedge clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= !wr;
      // No local limit: only the watchdog may end a wait that never ends.
      do begin
        @(posedge clk_in);
      end while (stall !== 1'b0);
      rd = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
    end
  endtask
  task automatic rdx(input logic [4:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      `SEF_CHK(rd, exp)
    end
  endtask
  // One frame from the far master, long enough for it to finish.
  task automatic xfer(input logic [7:0] b);
    begin
      @(posedge clk_in);
      p_byte <= b;
      p_go <= 1'b1;
      repeat (90) @(posedge clk_in);
      p_go <= 1'b0;
    end
  endtask
  task automatic t_reset();
    begin
      rdx(`SEF_OFF_CTRL, 32'h04);
      rdx(`SEF_OFF_DIV, 32'h04);
      bus(1'b1, `SEF_OFF_STAT, 32'hF);
      rdx(`SEF_OFF_STAT, 32'h0);
      rdx(`SEF_OFF_CLR, 32'h0);
      rdx(`SEF_OFF_IEN, 32'h0);
      rdx(5'h18, 32'h0);
      $display("reset test done");
    end
  endtask
  // Four-wire then three-wire slave byte.
  task automatic t_slave();
    logic [31:0] mode [2] = '{32'h05, 32'h01};
    begin
      bus(1'b1, `SEF_OFF_IEN, 32'hF);
      foreach (mode[i]) begin
        bus(1'b1, `SEF_OFF_CTRL, mode[i]);
        bus(1'b1, `SEF_OFF_DATA, 32'h3C);
        xfer(8'hA5);
        `SEF_CHK(irq_out, 1'b1)
        `SEF_CHK(p_rx, 8'h3C)
        rdx(`SEF_OFF_CTRL, 32'h80 | mode[i]);
        rdx(`SEF_OFF_DATA, 32'hA5);
        bus(1'b1, `SEF_OFF_CLR, 32'h8);
        repeat (3) @(posedge clk_in);
        `SEF_CHK(irq_out, 1'b0)
      end
      $display("slave test done");
    end
  endtask
  task automatic t_overrun();
    begin
      bus(1'b1, `SEF_OFF_CTRL, 32'h05);
      xfer(8'h11);
      xfer(8'h22);
      rdx(`SEF_OFF_STAT, 32'h9);
      rdx(`SEF_OFF_DATA, 32'h11);
      bus(1'b1, `SEF_OFF_CLR, 32'hF);
      $display("overrun test done");
    end
  endtask
  task automatic t_write_collision_flag();
    begin
      bus(1'b1, `SEF_OFF_DATA, 32'h55);
      bus(1'b1, `SEF_OFF_DATA, 32'h66);
      bus(1'b1, `SEF_OFF_DATA, 32'h77);
      rdx(`SEF_OFF_STAT, 32'h4);
      xfer(8'h00);
      `SEF_CHK(p_rx, 8'h55)
      rdx(`SEF_OFF_DATA, 32'h00);
      xfer(8'h01);
      `SEF_CHK(p_rx, 8'h66)
      rdx(`SEF_OFF_STAT, 32'hC);
      bus(1'b1, `SEF_OFF_CLR, 32'hF);
      $display("collision test done");
    end
  endtask
  // Master byte on a looped line, then another master takes the bus.
  task automatic t_master();
    int n;
    begin
      bus(1'b1, `SEF_OFF_DIV, 32'h03);
      rdx(`SEF_OFF_DIV, 32'h03);
      bus(1'b1, `SEF_OFF_CTRL, 32'h07);
      bus(1'b1, `SEF_OFF_DATA, 32'h96);
      for (n = 0; n < 300 && irq_out !== 1'b1; n++) @(posedge clk_in);
      `SEF_CHK(irq_out, 1'b1)
      rdx(`SEF_OFF_STAT, 32'h8);
      rdx(`SEF_OFF_DATA, 32'h96);
      bus(1'b1, `SEF_OFF_CLR, 32'hF);
      xfer(8'h00);
      rdx(`SEF_OFF_CTRL, 32'h24);
      `SEF_CHK(irq_out, 1'b1)
      bus(1'b1, `SEF_OFF_CLR, 32'hF);
      repeat (3) @(posedge clk_in);
      `SEF_CHK(irq_out, 1'b0)
      // Master driving its own select low is no fault outside mode 01.
      bus(1'b1, `SEF_OFF_CTRL, 32'h0B);
      rdx(`SEF_OFF_CTRL, 32'h0B);
      `SEF_CHK({ss_oe, ss_o}, 2'b10)
      bus(1'b1, `SEF_OFF_CTRL, 32'h00);
      $display("master test done");
    end
  endtask
  task automatic close_out();
    begin
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_slave();
    t_overrun();
    t_write_collision_flag();
    t_master();
    close_out();
  end
  // The run needs about 40 us; this cuts a hang short.
  initial begin
    #400000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule
